/* File: pkg/smp_pkg.sv */
// Summary of operation
// R1: role bit set means master; clear means slave taking the serial clock pin as input.
// R2: only a master starts a transfer, launched by a data register write.
// R3: data write with empty shifter loads it at once and sets transmit empty.
// R4: master shifts in from MISO while shifting out on MOSI.
// R5: transfer ends when receive full sets; received byte moves to receive register then.
// R6: receive full clears only after status read followed by data read.
// R7: a data register write clears the transmit interrupt enable.
// R8: in master role two rate bits pick four clock rates, fastest bus/2.
// R9: receive full and transmit empty each raise an interrupt with own enable.
// R10: master holds slave select low from before transfer until it completes; this port has no select output, so select is left to outside logic.
// R11: slave copies each complete byte to receive register and sets receive full.
// R12: slave accepts any serial clock up to bus rate, ignoring rate bits; the pin is sampled once per bus cycle here, so at most bus/2.
// R13: slave software writes next byte a cycle early, else old byte resent.
// R14: slave write during a transfer waits in a buffer until it ends.
// R15: slave starts on first clock edge with phase set, select fall otherwise.
// R16: unselected slave leaves the bus alone; master may flag select contention.
// R17: role fault and overrun flags exist and can request an interrupt.
// R18: polarity bit picks clock idle level; with phase gives four formats.
// R19: master and slave should use matching phase and polarity.
// R20: software clears port enable before changing polarity or phase.
// R21: set roles before enabling; enable master first, disable slave first.
// R22: serial clock sits at idle level when a slave is enabled.
// R23: master start follows data write within one bit time.
// R24: overrun sets if receive register unread at second capture; new byte dropped.
// R25: slave drives MISO only while its select is low.
// R26: with phase clear, master raises and lowers select between bytes; this port drives no select pin, so that is left to outside logic.
// R27: eight bits per transfer, MSB first, both directions at once.
package smp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map
  localparam int SMP_ADDR_W = 8;
  localparam logic [7:0] SMP_CTRL_ADDR = 8'h0D;
  localparam logic [7:0] SMP_STAT_ADDR = 8'h0E;
  localparam logic [7:0] SMP_DATA_ADDR = 8'h0F;

  // control register fields
  localparam int SMP_CTRL_RXIE = 7;
  localparam int SMP_CTRL_ROLE = 5;
  localparam int SMP_CTRL_CLOCK_POLARITY_SELECT = 4;
  localparam int SMP_CTRL_CLOCK_PHASE_SELECT = 3;
  localparam int SMP_CTRL_EN = 1;
  localparam int SMP_CTRL_TXIE = 0;
  localparam logic [7:0] SMP_CTRL_RESET = 8'h29;

  // status and control register fields
  localparam int SMP_STAT_ERRIE = 6;
  localparam int SMP_STAT_FLTEN = 2;
  localparam int SMP_STAT_RATE_HI = 1;
  localparam int SMP_STAT_RATE_LO = 0;
  localparam logic [7:0] SMP_STAT_RESET = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // timing: half a serial bit in bus cycles per rate setting
  localparam int SMP_DIV_W = 7;
  localparam logic [6:0] SMP_HALF_DIV2 = 7'h01;
  localparam logic [6:0] SMP_HALF_DIV8 = 7'h04;
  localparam logic [6:0] SMP_HALF_DIV32 = 7'h10;
  localparam logic [6:0] SMP_HALF_DIV128 = 7'h40;
  localparam logic [4:0] SMP_EDGES = 5'h10;
  localparam logic [3:0] SMP_OVR_PAIR = 4'h1;
  localparam logic [7:0] SMP_ZERO = 8'h00;

  // state of the shift engine
  typedef enum logic {SMP_IDLE = 1'b0, SMP_BUSY = 1'b1} smp_state_type;

  // pins toward the link
  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic ss_n;
  } smp_pin_in_type;

  typedef struct packed {
    logic sck;
    logic sck_oe;
    logic mosi;
    logic mosi_oe;
    logic miso;
    logic miso_oe;
  } smp_pin_out_type;

  // half bit length for a rate code
  function automatic logic [6:0] smp_half(input logic [1:0] rate);
    unique case (rate)
      2'h0: smp_half = SMP_HALF_DIV2;
      2'h1: smp_half = SMP_HALF_DIV8;
      2'h2: smp_half = SMP_HALF_DIV32;
      2'h3: smp_half = SMP_HALF_DIV128;
    endcase
  endfunction : smp_half

endpackage : smp_pkg

/* File: rtl/smp_port.sv */
`timescale 1ns/1ps
module smp_port (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic [smp_pkg::SMP_ADDR_W-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire smp_pkg::smp_pin_in_type pin_i,
  output smp_pkg::smp_pin_out_type pin_o,
  output logic rx_irq_o,
  output logic tx_irq_o
);
  import smp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  smp_pin_in_type pin_meta_r;
  smp_pin_in_type pin_sync_r;
  logic sck_prev_r;
  logic ss_prev_r;
  logic rxie_r, role_r, clock_polarity_select_r, clock_phase_select_r, en_r, txie_r;
  logic errie_r, flten_r;
  logic [1:0] rate_r;
  logic rxf_r, ovr_r, fault_r, txe_r;
  logic rxf_armed_r, ovr_armed_r, fault_armed_r;
  logic [7:0] txbuf_r, rxdata_r, sh_r, rdata_r;
  logic dout_r, pending_r, sck_act_r;
  smp_state_type state_r;
  logic [4:0] edge_cnt_r;
  logic [6:0] div_cnt_r;
  logic wr_ctrl, wr_stat, wr_data, rd_stat, rd_data;
  logic busy, active_m, tick, ss_low, sck_edge, ss_fall, slave_ok;
  logic fault_ev, m_start, s_start, xf_start, xf_edge, leading;
  logic drive_ev, sample_ev, last_edge, abort, sh_free, din;
  logic load_now, ovr_set;
  logic [7:0] load_val, rx_word;
  logic [1:0] m_smp_r, m_end_r;
  logic [7:0] m_rx_r, rx_cap;
  logic rx_done;

  ////////////////////////////////////////////////////////////////////////////
  // bus strobes, gated by the clock enable
  assign wr_ctrl = ce_i & wr_i & (addr_i == SMP_CTRL_ADDR);
  assign wr_stat = ce_i & wr_i & (addr_i == SMP_STAT_ADDR);
  assign wr_data = ce_i & wr_i & (addr_i == SMP_DATA_ADDR);
  assign rd_stat = ce_i & rd_i & (addr_i == SMP_STAT_ADDR);
  assign rd_data = ce_i & rd_i & (addr_i == SMP_DATA_ADDR);

  // two-flop synchronisers on every pin input
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pin_meta_r <= '{sck: 1'b0, mosi: 1'b0, miso: 1'b0, ss_n: 1'b1};
      pin_sync_r <= '{sck: 1'b0, mosi: 1'b0, miso: 1'b0, ss_n: 1'b1};
    end else if (ce_i) begin
      pin_meta_r <= pin_i;
      pin_sync_r <= pin_meta_r;
    end
  end

  // edge detection on the synchronised clock and select
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sck_prev_r <= 1'b0;
      ss_prev_r <= 1'b1;
    end else if (ce_i) begin
      sck_prev_r <= pin_sync_r.sck;
      ss_prev_r <= pin_sync_r.ss_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transfer events
  assign busy = (state_r == SMP_BUSY);
  assign active_m = en_r & role_r; // R1
  assign tick = ce_i & active_m & (div_cnt_r == smp_half(rate_r) - 7'h01); // R8
  assign ss_low = ~pin_sync_r.ss_n;
  // slave edges come from the pin, not the divider
  assign sck_edge = ce_i & (pin_sync_r.sck != sck_prev_r); // R12
  assign ss_fall = ce_i & ss_prev_r & ~pin_sync_r.ss_n;
  assign slave_ok = en_r & ~role_r & ss_low; // R1 R16
  // select pulled low while master means another master is out there
  assign fault_ev = ce_i & active_m & flten_r & ss_low; // R16 R17
  assign m_start = ~busy & tick & pending_r & ~fault_ev; // R2 R23
  assign s_start = ~busy & slave_ok & (clock_phase_select_r ? sck_edge : ss_fall); // R15
  assign xf_start = m_start | s_start;
  assign xf_edge = (busy & role_r & tick) | (slave_ok & sck_edge & (busy | clock_phase_select_r));
  assign leading = ~edge_cnt_r[0];
  // phase set: drive on leading, sample on trailing; clear: the reverse
  assign drive_ev = xf_edge & (leading == clock_phase_select_r); // R18
  assign sample_ev = xf_edge & (leading != clock_phase_select_r); // R4
  assign last_edge = xf_edge & (edge_cnt_r == SMP_EDGES - 5'h01); // R27
  assign abort = busy & (~en_r | fault_ev | (~role_r & ~ss_low));
  assign sh_free = ~busy & ~xf_start & (~role_r | ~pending_r);
  assign din = role_r ? pin_sync_r.miso : pin_sync_r.mosi; // R4
  assign rx_word = clock_phase_select_r ? {sh_r[6:0], din} : sh_r;
  assign load_now = last_edge & (~txe_r | wr_data);
  assign load_val = txe_r ? wdata_i : txbuf_r;
  assign ovr_set = sample_ev & rxf_r & (edge_cnt_r[4:1] == SMP_OVR_PAIR); // R24
  // master capture runs two cycles late to match the miso synchroniser
  assign rx_done = role_r ? (ce_i & m_end_r[1]) : last_edge; // R5 R11
  assign rx_cap = role_r ? (m_smp_r[1] ? {m_rx_r[6:0], pin_sync_r.miso} : m_rx_r) : rx_word;

  ////////////////////////////////////////////////////////////////////////////
  // free-running baud divider, only while master and enabled
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      div_cnt_r <= 7'h00;
    end else if (ce_i) begin
      if (!active_m || tick) begin
        div_cnt_r <= 7'h00;
      end else begin
        div_cnt_r <= div_cnt_r + 7'h01;
      end
    end
  end

  // transfer state and edge counter
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_r <= SMP_IDLE;
      edge_cnt_r <= 5'h00;
    end else if (ce_i) begin
      if (abort || last_edge) begin
        state_r <= SMP_IDLE;
        edge_cnt_r <= 5'h00;
      end else begin
        if (xf_start) begin
          state_r <= SMP_BUSY;
        end
        if (xf_edge) begin
          edge_cnt_r <= edge_cnt_r + 5'h01; // R27
        end
      end
    end
  end

  // serial clock level of the master
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sck_act_r <= 1'b0;
    end else if (ce_i) begin
      if (abort || last_edge || !busy) begin
        sck_act_r <= 1'b0;
      end else if (xf_edge && role_r) begin
        sck_act_r <= ~sck_act_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shift register: load, then sample msb first
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sh_r <= SMP_ZERO;
    end else if (ce_i) begin
      if (load_now) begin
        sh_r <= load_val; // R14
      end else if (wr_data && sh_free) begin
        sh_r <= wdata_i; // R3
      end else if (sample_ev) begin
        sh_r <= {sh_r[6:0], din}; // R4 R27
      end
    end
  end

  // serial output bit
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      dout_r <= 1'b0;
    end else if (ce_i) begin
      if ((xf_start && !clock_phase_select_r) || drive_ev) begin
        dout_r <= sh_r[7]; // R27
      end
    end
  end

  // shifter holds a byte that has not gone out yet
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pending_r <= 1'b0;
    end else if (ce_i) begin
      if (load_now || (wr_data && sh_free)) begin
        pending_r <= 1'b1;
      end else if (xf_start || last_edge) begin
        pending_r <= 1'b0; // R13
      end
    end
  end

  // transmit buffer and empty flag
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      txbuf_r <= SMP_ZERO;
      txe_r <= 1'b1;
    end else if (ce_i) begin
      if (wr_data && !sh_free && !(last_edge && txe_r)) begin
        txbuf_r <= wdata_i; // R14
        txe_r <= 1'b0;
      end else if (last_edge && !txe_r) begin
        txe_r <= 1'b1;
      end else if (wr_data && sh_free) begin
        txe_r <= 1'b1; // R3
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // master receive shifter, strobes delayed by the synchroniser depth
  // without this a bus/2 master would sample miso one bit too early
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      m_smp_r <= 2'h0;
      m_end_r <= 2'h0;
      m_rx_r <= SMP_ZERO;
    end else if (ce_i) begin
      m_smp_r <= {m_smp_r[0], sample_ev & role_r};
      m_end_r <= {m_end_r[0], last_edge & role_r};
      if (m_smp_r[1]) begin
        m_rx_r <= {m_rx_r[6:0], pin_sync_r.miso}; // R4 R27
      end
    end
  end

  // receive register and receive full flag, loaded only while the flag is clear
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rxdata_r <= SMP_ZERO;
      rxf_r <= 1'b0;
      rxf_armed_r <= 1'b0;
    end else if (ce_i) begin
      if (rx_done && !rxf_r) begin
        rxdata_r <= rx_cap; // R5 R11
        rxf_r <= 1'b1;
      end else if (rd_data && rxf_armed_r) begin
        rxf_r <= 1'b0; // R6
      end
      if (rd_data) begin
        rxf_armed_r <= 1'b0;
      end else if (rd_stat && rxf_r) begin
        rxf_armed_r <= 1'b1; // R6
      end
    end
  end

  // overrun flag, cleared by status read then data read
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ovr_r <= 1'b0;
      ovr_armed_r <= 1'b0;
    end else if (ce_i) begin
      if (ovr_set) begin
        ovr_r <= 1'b1; // R24
      end else if (rd_data && ovr_armed_r) begin
        ovr_r <= 1'b0;
      end
      if (rd_data) begin
        ovr_armed_r <= 1'b0;
      end else if (rd_stat && ovr_r) begin
        ovr_armed_r <= 1'b1;
      end
    end
  end

  // role fault flag, cleared by status read then control write
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      fault_r <= 1'b0;
      fault_armed_r <= 1'b0;
    end else if (ce_i) begin
      if (fault_ev) begin
        fault_r <= 1'b1; // R17
      end else if (wr_ctrl && fault_armed_r) begin
        fault_r <= 1'b0;
      end
      if (wr_ctrl) begin
        fault_armed_r <= 1'b0;
      end else if (rd_stat && fault_r) begin
        fault_armed_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rxie_r <= SMP_CTRL_RESET[SMP_CTRL_RXIE];
      role_r <= SMP_CTRL_RESET[SMP_CTRL_ROLE];
      clock_polarity_select_r <= SMP_CTRL_RESET[SMP_CTRL_CLOCK_POLARITY_SELECT];
      clock_phase_select_r <= SMP_CTRL_RESET[SMP_CTRL_CLOCK_PHASE_SELECT];
      en_r <= SMP_CTRL_RESET[SMP_CTRL_EN];
    end else if (wr_ctrl) begin
      rxie_r <= wdata_i[SMP_CTRL_RXIE];
      role_r <= wdata_i[SMP_CTRL_ROLE]; // R1
      clock_polarity_select_r <= wdata_i[SMP_CTRL_CLOCK_POLARITY_SELECT]; // R18
      clock_phase_select_r <= wdata_i[SMP_CTRL_CLOCK_PHASE_SELECT]; // R18
      en_r <= wdata_i[SMP_CTRL_EN];
    end
  end

  // transmit interrupt enable, dropped by any data write
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      txie_r <= SMP_CTRL_RESET[SMP_CTRL_TXIE];
    end else if (wr_data) begin
      txie_r <= 1'b0; // R7
    end else if (wr_ctrl) begin
      txie_r <= wdata_i[SMP_CTRL_TXIE];
    end
  end

  // writable bits of the status and control register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      errie_r <= SMP_STAT_RESET[SMP_STAT_ERRIE];
      flten_r <= SMP_STAT_RESET[SMP_STAT_FLTEN];
      rate_r <= SMP_STAT_RESET[SMP_STAT_RATE_HI:SMP_STAT_RATE_LO];
    end else if (wr_stat) begin
      errie_r <= wdata_i[SMP_STAT_ERRIE];
      flten_r <= wdata_i[SMP_STAT_FLTEN];
      rate_r <= wdata_i[SMP_STAT_RATE_HI:SMP_STAT_RATE_LO]; // R8
    end
  end

  // read data, one cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_r <= SMP_ZERO;
    end else if (ce_i && rd_i) begin
      unique case (addr_i)
        SMP_CTRL_ADDR: rdata_r <= {rxie_r, 1'b0, role_r, clock_polarity_select_r, clock_phase_select_r, 1'b0, en_r, txie_r};
        SMP_STAT_ADDR: rdata_r <= {rxf_r, errie_r, ovr_r, fault_r, txe_r, flten_r, rate_r};
        SMP_DATA_ADDR: rdata_r <= rxdata_r;
        default: rdata_r <= SMP_ZERO;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign rdata_o = rdata_r;
  assign pin_o.sck = clock_polarity_select_r ^ sck_act_r; // R18
  assign pin_o.sck_oe = active_m;
  assign pin_o.mosi = dout_r;
  assign pin_o.mosi_oe = active_m;
  assign pin_o.miso = dout_r;
  assign pin_o.miso_oe = slave_ok; // R25 R16
  // error flags share the receive interrupt line
  assign rx_irq_o = (rxie_r & rxf_r) | (errie_r & (ovr_r | fault_r)); // R9 R17
  assign tx_irq_o = txie_r & txe_r; // R9

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_txe_on_load: assert property (@(posedge clk_i) disable iff (srst_i || !ce_i)
    wr_data && sh_free |=> txe_r) else $error("empty flag not set on load"); // R3
  a_txie_cleared: assert property (@(posedge clk_i) disable iff (srst_i || !ce_i)
    wr_data |=> !txie_r) else $error("tx irq enable kept after data write"); // R7
  a_rx_capture: assert property (@(posedge clk_i) disable iff (srst_i || !ce_i)
    rx_done && !rxf_r |=> rxf_r && rxdata_r == $past(rx_cap))
    else $error("received byte not captured"); // R5
  a_rxf_holds: assert property (@(posedge clk_i) disable iff (srst_i || !ce_i)
    rxf_r && !(rd_data && rxf_armed_r) |=> rxf_r)
    else $error("receive full dropped without read pair"); // R6
  a_ovr_raise: assert property (@(posedge clk_i) disable iff (srst_i || !ce_i)
    ovr_set |=> ovr_r ##1 ovr_r || $past(rd_data)) else $error("overrun not flagged"); // R24
  a_ovr_keeps_byte: assert property (@(posedge clk_i) disable iff (srst_i || !ce_i)
    rx_done && rxf_r |=> $stable(rxdata_r)) else $error("unread byte overwritten"); // R24
  a_start_delay: assert property (@(posedge clk_i) disable iff (srst_i || !ce_i)
    wr_data && sh_free && active_m && !flten_r |-> ##[1:129] busy)
    else $error("master start too late"); // R23
  a_slave_waits: assert property (@(posedge clk_i) disable iff (srst_i || !ce_i)
    !role_r && !busy && pin_sync_r.ss_n |=> !busy) else $error("slave started unselected"); // R2
  a_miso_quiet: assert property (@(posedge clk_i) disable iff (srst_i || !ce_i)
    pin_sync_r.ss_n || role_r |-> !pin_o.miso_oe) else $error("miso driven unselected"); // R25

  c_master_byte: cover property (@(posedge clk_i) disable iff (srst_i) last_edge && role_r);
  c_slave_byte: cover property (@(posedge clk_i) disable iff (srst_i) last_edge && !role_r);
  c_overrun: cover property (@(posedge clk_i) disable iff (srst_i) ovr_set);
  c_role_fault: cover property (@(posedge clk_i) disable iff (srst_i) fault_ev);

endmodule : smp_port

/* File: verification/smp_far_end.sv */
`timescale 1ns/1ps
module smp_far_end (
  input wire logic master_i,
  input wire logic clock_polarity_select_i,
  input wire logic clock_phase_select_i,
  input wire logic sel_n_i,
  input wire logic sck_i,
  input wire logic mosi_i,
  input wire logic miso_i,
  output logic sck_o,
  output logic mosi_o,
  output logic miso_o,
  output logic ss_n_o
);
  logic [7:0] sh = 8'h00;
  logic [7:0] rx = 8'h00;
  // lines start quiet, select released
  initial begin
    sck_o = 1'b0;
    mosi_o = 1'b0;
    miso_o = 1'b0;
    ss_n_o = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////
  // clock rests at the idle level of the shared format between frames
  always @(clock_polarity_select_i) if (ss_n_o) sck_o = clock_polarity_select_i;
  // slave side: next byte to send
  task automatic load(input logic [7:0] b);
    sh = b;
  endtask : load
  // phase 0 needs the first bit out before the first clock edge
  always @(negedge sel_n_i) begin
    if (!master_i && !clock_phase_select_i) begin
      miso_o = sh[7];
      sh = sh << 1;
    end
  end
  // a released data line must not keep showing the last bit
  always @(posedge sel_n_i) miso_o = ~miso_o;
  // drive on one edge, sample on the other, msb first
  always @(sck_i) begin
    if (!master_i && !sel_n_i) begin
      if ((sck_i != clock_polarity_select_i) == clock_phase_select_i) begin
        miso_o = sh[7];
        sh = sh << 1;
      end else begin
        rx = {rx[6:0], mosi_i};
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // master side: one byte at 160 ns a bit, off the bus clock phase
  task automatic xfer(input logic [7:0] tx, output logic [7:0] got);
    got = 8'h00;
    #7;
    ss_n_o = 1'b0;
    mosi_o = tx[7];
    #160;
    for (int i = 7; i >= 0; i--) begin
      sck_o = ~sck_o;
      if (clock_phase_select_i) mosi_o = tx[i];
      else got = {got[6:0], miso_i};
      #80;
      sck_o = ~sck_o;
      if (clock_phase_select_i) got = {got[6:0], miso_i};
      else if (i > 0) mosi_o = tx[i - 1];
      #80;
    end
    mosi_o = ~mosi_o;
    ss_n_o = 1'b1;
    #160;
  endtask : xfer
endmodule : smp_far_end

/* File: verification/smp_port_bench.sv */
`timescale 1ns/1ps
module smp_port_bench;
  import smp_pkg::*;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rdata_o;
  logic rx_irq_o;
  logic tx_irq_o;
  smp_pin_in_type pin_i;
  smp_pin_out_type pin_o;
  logic far_master = 1'b0;
  logic clock_polarity_select = 1'b0;
  logic clock_phase_select = 1'b1;
  logic sel_n = 1'b1;
  logic far_sck;
  logic far_mosi;
  logic far_miso;
  logic far_ss_n;
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  // 50 MHz bus clock
  always #10 clk_i = ~clk_i;
  // resolve each shared line from whoever enables it
  always_comb begin
    pin_i.sck = pin_o.sck_oe ? pin_o.sck : far_sck;
    pin_i.mosi = pin_o.mosi_oe ? pin_o.mosi : far_mosi;
    pin_i.miso = pin_o.miso_oe ? pin_o.miso : far_miso;
    pin_i.ss_n = far_master ? far_ss_n : 1'b1;
  end
  smp_port smp_port_inst (.clk_i(clk_i), .srst_i(srst_i), .ce_i(1'b1), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_i(pin_i),
    .pin_o(pin_o), .rx_irq_o(rx_irq_o), .tx_irq_o(tx_irq_o));
  smp_far_end smp_far_end_inst (.master_i(far_master), .clock_polarity_select_i(clock_polarity_select), .clock_phase_select_i(clock_phase_select),
    .sel_n_i(sel_n), .sck_i(pin_i.sck), .mosi_i(pin_i.mosi), .miso_i(pin_i.miso),
    .sck_o(far_sck), .mosi_o(far_mosi), .miso_o(far_miso), .ss_n_o(far_ss_n));
  ////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude
  // byte compare
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // register bus cycles
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask : rd
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp);
  endtask : rdc
  // wait for the receive interrupt, bounded
  task automatic wait_rx;
    for (int i = 0; i < 3000 && rx_irq_o !== 1'b1; i++) @(posedge clk_i);
    #1;
  endtask : wait_rx
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rdc(SMP_CTRL_ADDR, 8'h29);
    rdc(SMP_STAT_ADDR, 8'h08);
    rdc(8'h10, 8'h00);
    chk({7'h00, tx_irq_o}, 8'h01);
    chk({7'h00, rx_irq_o}, 8'h00);
    wr(SMP_STAT_ADDR, 8'hFF);
    rdc(SMP_STAT_ADDR, 8'h4F);
    wr(SMP_STAT_ADDR, 8'h00);
    $display("test reset done");
  endtask : t_reset
  // master byte in format f at rate code f
  task automatic t_master(input logic [1:0] f);
    logic [7:0] tx;
    logic [7:0] ctl;
    tx = 8'hA5 ^ {f, f, f, f};
    ctl = {3'b101, f, 3'b001};
    clock_polarity_select <= f[1];
    clock_phase_select <= f[0];
    wr(SMP_CTRL_ADDR, ctl);
    wr(SMP_STAT_ADDR, {6'h00, f});
    wr(SMP_CTRL_ADDR, ctl | 8'h02);
    smp_far_end_inst.load(~tx);
    sel_n <= 1'b0;
    wr(SMP_DATA_ADDR, tx);
    rdc(SMP_CTRL_ADDR, (ctl | 8'h02) & 8'hFE);
    chk({7'h00, tx_irq_o}, 8'h00);
    rdc(SMP_STAT_ADDR, 8'h08 | f);
    wait_rx();
    chk(smp_far_end_inst.rx, tx);
    rdc(SMP_STAT_ADDR, 8'h88 | f);
    rdc(SMP_DATA_ADDR, ~tx);
    rdc(SMP_STAT_ADDR, 8'h08 | f);
    sel_n <= 1'b1;
    wr(SMP_CTRL_ADDR, ctl);
    $display("test master format %0d done", f);
  endtask : t_master
  // unread byte survives a second frame
  task automatic t_overrun;
    logic [7:0] s;
    s = 8'h00;
    clock_polarity_select <= 1'b0;
    clock_phase_select <= 1'b1;
    wr(SMP_STAT_ADDR, 8'h00);
    wr(SMP_CTRL_ADDR, 8'hAA);
    smp_far_end_inst.load(8'h12);
    sel_n <= 1'b0;
    wr(SMP_DATA_ADDR, 8'h21);
    wait_rx();
    rdc(SMP_DATA_ADDR, 8'h12);
    rdc(SMP_STAT_ADDR, 8'h88);
    smp_far_end_inst.load(8'h34);
    wr(SMP_DATA_ADDR, 8'h43);
    for (int i = 0; i < 200 && !s[5]; i++) rd(SMP_STAT_ADDR, s);
    // let the dropped frame finish
    repeat (40) @(posedge clk_i);
    rdc(SMP_STAT_ADDR, 8'hA8);
    rdc(SMP_DATA_ADDR, 8'h12);
    rdc(SMP_STAT_ADDR, 8'h08);
    sel_n <= 1'b1;
    $display("test overrun done");
  endtask : t_overrun
  // slave byte pair under an outside clock
  task automatic t_slave(input logic ph);
    logic [7:0] got;
    far_master <= 1'b1;
    clock_phase_select <= ph;
    wr(SMP_CTRL_ADDR, {4'h8, ph, 3'b000});
    wr(SMP_CTRL_ADDR, {4'h8, ph, 3'b010});
    wr(SMP_DATA_ADDR, 8'hC3);
    rdc(SMP_STAT_ADDR, 8'h08);
    chk({7'h00, pin_o.miso_oe}, 8'h00);
    fork
      smp_far_end_inst.xfer(8'h6E, got);
      begin
        repeat (30) @(posedge clk_i);
        chk({7'h00, pin_o.miso_oe}, 8'h01);
        wr(SMP_DATA_ADDR, 8'h99);
      end
    join
    chk(got, 8'hC3);
    wait_rx();
    rdc(SMP_STAT_ADDR, 8'h88);
    rdc(SMP_DATA_ADDR, 8'h6E);
    chk({7'h00, pin_o.miso_oe}, 8'h00);
    smp_far_end_inst.xfer(8'h55, got);
    chk(got, 8'h99);
    wait_rx();
    rdc(SMP_STAT_ADDR, 8'h88);
    rdc(SMP_DATA_ADDR, 8'h55);
    $display("test slave phase %0d done", ph);
  endtask : t_slave
  ////////////////////////////////////////////////////////////////////////
  // hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      conclude();
    end
  end
  // main sequence
  initial begin
    repeat (6) @(posedge clk_i);
    srst_i <= 1'b0;
    t_reset();
    for (int f = 0; f < 4; f++) t_master(f[1:0]);
    t_overrun();
    t_slave(1'b0);
    t_slave(1'b1);
    conclude();
  end
endmodule : smp_port_bench
